/* hdl/cpu_logic_branch_decode.sv */
// Functional notes
// RULE1 - AND operand into accumulator low, NZ, V clear
// RULE2 - OR operand into accumulator low, NZ, V clear
// RULE3 - Stack pointer inc/dec, three cycles, flags kept
// RULE4 - Branch on zero set or clear
// RULE5 - Branch on carry set or clear
// RULE6 - Branch on negative set or clear
// RULE7 - Branch on overflow xor negative
// RULE8 - Direct bit test branch, Z updated, five cycles
// RULE9 - Exchange accumulator with program counter plus one
// RULE10 - Unmarked flags keep their prior values
// RULE11 - Untaken relative branch only advances program counter
// RULE12 - Interrupt return restores flags and program counter
`timescale 1ns/1ps
`include "cpu_logic_branch_decode_consts.svh"
module cpu_logic_branch_decode
    import cpu_logic_branch_decode_pkg::*;
#(
    parameter int CYC_W = 4
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire instr_t i_instr,
    input wire core_regs_t i_regs,
    output logic o_ready,
    output logic o_done,
    output logic o_illegal,
    output core_regs_t o_result
);
    // Refused at elaboration: the six-cycle interrupt return needs a three-bit count
    if (CYC_W < 3) begin : g_cyc_w_check
        $error("CYC_W too narrow for the longest instruction");
    end

    function automatic logic [3:0] op_cycles(input logic [7:0] op);
        logic [3:0] c;
        c = 4'h0;
        if ((op & `OP_BIT_MASK) == `OP_BIT_BRANCH) begin
            c = `CYC_FIVE;
        end else if ((op & `OP_REG_MASK) == `OP_AND_RI || (op & `OP_REG_MASK) == `OP_OR_RI) begin
            c = `CYC_THREE;
        end else begin
            unique case (op)
                `OP_AND_EP, `OP_OR_EP, `OP_OR_DIR, `OP_WORD_INCREMENT_OP_SP, `OP_WORD_DECREMENT_OP_SP, `OP_WORD_EXCHANGE_OP_PC: c = `CYC_THREE;
                `OP_AND_IX, `OP_OR_IX: c = `CYC_FOUR;
                `OP_OR_TL, `OP_OR_IMM: c = `CYC_TWO;
                `OP_BNC, `OP_BC, `OP_BP, `OP_BN, `OP_BNZ, `OP_BZ, `OP_BGE, `OP_BLT: c = `CYC_THREE;
                `OP_INTERRUPT_RETURN_OP: c = `CYC_SIX;
                default: c = 4'h0;
            endcase
        end
        return c;
    endfunction : op_cycles

    function automatic logic [15:0] op_len(input logic [7:0] op);
        logic [15:0] n;
        n = `LEN_ONE;
        if ((op & `OP_BIT_MASK) == `OP_BIT_BRANCH) begin
            n = `LEN_THREE;
        end else if (op == `OP_AND_IX || op == `OP_OR_IMM || op == `OP_OR_DIR || op == `OP_OR_IX
                     || (op >= `OP_BNC && op != `OP_WORD_EXCHANGE_OP_PC)) begin
            n = `LEN_TWO;
        end
        return n;
    endfunction : op_len

    function automatic logic is_logic_or(input logic [7:0] op);
        return op == `OP_OR_TL || op == `OP_OR_IMM || op == `OP_OR_DIR || op == `OP_OR_IX
               || op == `OP_OR_EP || (op & `OP_REG_MASK) == `OP_OR_RI;
    endfunction : is_logic_or

    function automatic logic is_logic_and(input logic [7:0] op);
        return op == `OP_AND_EP || op == `OP_AND_IX || (op & `OP_REG_MASK) == `OP_AND_RI;
    endfunction : is_logic_and

    function automatic logic is_rel_branch(input logic [7:0] op);
        return op >= `OP_BNC && op != `OP_WORD_EXCHANGE_OP_PC;
    endfunction : is_rel_branch

    // Condition for every relative and bit branch; false means fall through
    function automatic logic branch_taken(input logic [7:0] op, input logic [7:0] ccr, input logic [7:0] mem);
        logic b;
        b = mem[op[2:0]];
        unique case (op)
            `OP_BZ: return ccr[`CCR_Z]; // RULE4
            `OP_BNZ: return !ccr[`CCR_Z]; // RULE4
            `OP_BC: return ccr[`CCR_C]; // RULE5
            `OP_BNC: return !ccr[`CCR_C]; // RULE5
            `OP_BN: return ccr[`CCR_N]; // RULE6
            `OP_BP: return !ccr[`CCR_N]; // RULE6
            `OP_BLT: return ccr[`CCR_V] ^ ccr[`CCR_N]; // RULE7
            `OP_BGE: return !(ccr[`CCR_V] ^ ccr[`CCR_N]); // RULE7
            default: return op[`OP_BIT_SEL] ? b : !b; // RULE8
        endcase
    endfunction : branch_taken

    function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] rel);
        return base + {{8{rel[7]}}, rel};
    endfunction : rel_target

    exec_state_t state, next_state;
    logic [CYC_W-1:0] count, next_count;
    logic done, next_done;
    logic illegal, next_illegal;
    instr_t cap, next_cap;
    core_regs_t regs, next_regs;
    core_regs_t result, next_result;

    logic [7:0] operand;
    logic [7:0] logic_res;
    logic [15:0] seq_pc;
    logic [7:0] rel;

    always_comb begin
        operand = (cap.opcode == `OP_OR_TL) ? regs.t[7:0]
                : (cap.opcode == `OP_OR_IMM) ? cap.op1 : cap.mem;
        logic_res = is_logic_and(cap.opcode) ? (regs.a[7:0] & operand) : (regs.a[7:0] | operand);
        seq_pc = regs.pc + op_len(cap.opcode);
        rel = ((cap.opcode & `OP_BIT_MASK) == `OP_BIT_BRANCH) ? cap.op2 : cap.op1;
    end

    always_comb begin
        next_state = state;
        next_count = count;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_cap = cap;
        next_regs = regs;
        next_result = result;
        unique case (state)
            ST_IDLE: begin
                if (i_start) begin
                    next_cap = i_instr;
                    next_regs = i_regs;
                    if (op_cycles(i_instr.opcode) == 4'h0) begin
                        // Unknown codes answer at once and leave the core untouched
                        next_done = 1'b1;
                        next_illegal = 1'b1;
                        next_result = i_regs;
                    end else begin
                        next_state = ST_EXEC;
                        next_count = CYC_W'(op_cycles(i_instr.opcode) - 4'h1);
                    end
                end
            end
            ST_EXEC: begin
                if (count != '0) begin
                    next_count = count - CYC_W'(1);
                end else begin
                    next_state = ST_IDLE;
                    next_done = 1'b1;
                    next_result = regs; // RULE10
                    next_result.pc = seq_pc; // RULE11
                    if (is_logic_and(cap.opcode) || is_logic_or(cap.opcode)) begin
                        next_result.a[7:0] = logic_res; // RULE1 RULE2
                        next_result.ccr[`CCR_N] = logic_res[7]; // RULE1 RULE2
                        next_result.ccr[`CCR_Z] = (logic_res == 8'h00); // RULE1 RULE2
                        next_result.ccr[`CCR_V] = 1'b0; // RULE1 RULE2
                    end else if (cap.opcode == `OP_WORD_INCREMENT_OP_SP) begin
                        next_result.sp = regs.sp + `WORD_ONE; // RULE3
                    end else if (cap.opcode == `OP_WORD_DECREMENT_OP_SP) begin
                        next_result.sp = regs.sp - `WORD_ONE; // RULE3
                    end else if (cap.opcode == `OP_WORD_EXCHANGE_OP_PC) begin
                        next_result.pc = regs.a; // RULE9
                        next_result.a = regs.pc + `WORD_ONE; // RULE9
                    end else if (cap.opcode == `OP_INTERRUPT_RETURN_OP) begin
                        next_result.pc = cap.stack_pc; // RULE12
                        next_result.ccr = cap.stack_ccr; // RULE12
                        next_result.sp = regs.sp + `INTERRUPT_RETURN_OP_SP_STEP;
                    end else begin
                        if ((cap.opcode & `OP_BIT_MASK) == `OP_BIT_BRANCH) begin
                            next_result.ccr[`CCR_Z] = !cap.mem[cap.opcode[2:0]]; // RULE8
                        end
                        if (branch_taken(cap.opcode, regs.ccr, cap.mem)) begin
                            next_result.pc = rel_target(seq_pc, rel); // RULE4 RULE5 RULE6 RULE7 RULE8
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            count <= '0;
            done <= 1'b0;
            illegal <= 1'b0;
            cap <= '0;
            regs <= '0;
            result <= '0;
            o_ready <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            done <= next_done;
            illegal <= next_illegal;
            cap <= next_cap;
            regs <= next_regs;
            result <= next_result;
            o_ready <= (next_state == ST_IDLE);
        end
    end

    assign o_done = done;
    assign o_illegal = illegal;
    assign o_result = result;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    logic fire;
    assign fire = i_start && state == ST_IDLE;
    sequence s_issue_word_increment_op;
        fire && i_instr.opcode == `OP_WORD_INCREMENT_OP_SP;
    endsequence
    sequence s_issue_word_decrement_op;
        fire && i_instr.opcode == `OP_WORD_DECREMENT_OP_SP;
    endsequence
    sequence s_issue_bit;
        fire && (i_instr.opcode & `OP_BIT_MASK) == `OP_BIT_BRANCH;
    endsequence
    // Issue may fall in the previous done cycle, so the busy span starts one edge later
    sequence s_finish;
        ##1 !o_done [*3] ##1 o_done;
    endsequence

    chk_and_result: assert property (o_done && is_logic_and(cap.opcode) |-> // RULE1
        o_result.a == {regs.a[15:8], regs.a[7:0] & cap.mem} && !o_result.ccr[`CCR_V]
        && o_result.ccr[`CCR_C] == regs.ccr[`CCR_C] && o_result.ccr[`CCR_N] == o_result.a[7])
        else $error("AND result or flags wrong");
    chk_or_result: assert property (o_done && is_logic_or(cap.opcode) |-> // RULE2
        o_result.a[7:0] == (regs.a[7:0] | operand) && o_result.ccr[`CCR_Z] == (o_result.a[7:0] == 8'h00)
        && !o_result.ccr[`CCR_V]) else $error("OR result or flags wrong");
    chk_sp_incr: assert property (s_issue_word_increment_op |-> s_finish ##0 // RULE3
        o_result.sp == $past(i_regs.sp, 4) + `WORD_ONE && o_result.ccr == $past(i_regs.ccr, 4))
        else $error("Stack increment wrong");
    chk_sp_decr: assert property (s_issue_word_decrement_op |-> ##4 o_done // RULE3
        && o_result.sp == $past(i_regs.sp, 4) - `WORD_ONE && o_result.ccr == $past(i_regs.ccr, 4))
        else $error("Stack decrement wrong");
    chk_zero_branch: assert property (o_done && (cap.opcode == `OP_BZ || cap.opcode == `OP_BNZ) |-> // RULE4
        o_result.pc == ((regs.ccr[`CCR_Z] ^ !cap.opcode[0]) ? rel_target(regs.pc + `LEN_TWO, cap.op1)
        : regs.pc + `LEN_TWO)) else $error("Zero branch target wrong");
    chk_carry_branch: assert property (o_done && cap.opcode == `OP_BC |-> // RULE5
        o_result.pc == (regs.ccr[`CCR_C] ? rel_target(regs.pc + `LEN_TWO, cap.op1) : regs.pc + `LEN_TWO)
        && o_result.ccr == regs.ccr) else $error("Carry branch wrong");
    chk_neg_branch: assert property (o_done && cap.opcode == `OP_BP |-> // RULE6
        o_result.pc == (!regs.ccr[`CCR_N] ? rel_target(regs.pc + `LEN_TWO, cap.op1) : regs.pc + `LEN_TWO))
        else $error("Negative branch wrong");
    chk_signed_branch: assert property (o_done && cap.opcode == `OP_BLT |-> // RULE7
        (o_result.pc != regs.pc + `LEN_TWO) == ((regs.ccr[`CCR_V] ^ regs.ccr[`CCR_N]) && cap.op1 != 8'h00))
        else $error("Signed branch wrong");
    chk_bit_branch: assert property (s_issue_bit |-> ##6 o_done // RULE8
        && o_result.ccr[`CCR_Z] == !cap.mem[cap.opcode[2:0]]) else $error("Bit branch wrong");
    chk_pc_exchange: assert property (o_done && cap.opcode == `OP_WORD_EXCHANGE_OP_PC |-> // RULE9
        o_result.pc == regs.a && o_result.a == regs.pc + `WORD_ONE) else $error("Exchange wrong");
    chk_untaken_keep: assert property (o_done && is_rel_branch(cap.opcode) && cap.opcode != `OP_WORD_EXCHANGE_OP_PC // RULE11
        && !branch_taken(cap.opcode, regs.ccr, cap.mem) |-> o_result.a == regs.a && o_result.sp == regs.sp
        && o_result.pc == regs.pc + `LEN_TWO) else $error("Untaken branch changed state");
    chk_interrupt_return_op_restore: assert property (o_done && cap.opcode == `OP_INTERRUPT_RETURN_OP |-> // RULE12
        o_result.ccr == cap.stack_ccr && o_result.pc == cap.stack_pc) else $error("Return restore wrong");
endmodule : cpu_logic_branch_decode

/* hdl/cpu_logic_branch_decode_consts.svh */
`ifndef CPU_LOGIC_BRANCH_DECODE_CONSTS_SVH
`define CPU_LOGIC_BRANCH_DECODE_CONSTS_SVH
`define OP_AND_IX 8'h66
`define OP_AND_EP 8'h67
`define OP_AND_RI 8'h68
`define OP_OR_TL 8'h72
`define OP_OR_IMM 8'h74
`define OP_OR_DIR 8'h75
`define OP_OR_IX 8'h76
`define OP_OR_EP 8'h77
`define OP_OR_RI 8'h78
`define OP_REG_MASK 8'hF8
`define OP_BIT_MASK 8'hF0
`define OP_BIT_BRANCH 8'hB0
`define OP_BIT_SEL 3
`define OP_WORD_INCREMENT_OP_SP 8'hC1
`define OP_WORD_DECREMENT_OP_SP 8'hD1
`define OP_BNC 8'hF8
`define OP_BC 8'hF9
`define OP_BP 8'hFA
`define OP_BN 8'hFB
`define OP_BNZ 8'hFC
`define OP_BZ 8'hFD
`define OP_BGE 8'hFE
`define OP_BLT 8'hFF
`define OP_WORD_EXCHANGE_OP_PC 8'hF4
`define OP_INTERRUPT_RETURN_OP 8'h30
`define CYC_TWO 4'h2
`define CYC_THREE 4'h3
`define CYC_FOUR 4'h4
`define CYC_FIVE 4'h5
`define CYC_SIX 4'h6
`define LEN_ONE 16'h0001
`define LEN_TWO 16'h0002
`define LEN_THREE 16'h0003
`define WORD_ONE 16'h0001
`define INTERRUPT_RETURN_OP_SP_STEP 16'h0004
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`define CCR_C 0
`define CCR_RESET 8'h00
`endif

/* hdl/cpu_logic_branch_decode_pkg.sv */
package cpu_logic_branch_decode_pkg;
    typedef struct packed {
        logic [15:0] a;
        logic [15:0] t;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0] ccr;
    } core_regs_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [7:0] mem;
        logic [15:0] stack_pc;
        logic [7:0] stack_ccr;
    } instr_t;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } exec_state_t;
endpackage : cpu_logic_branch_decode_pkg

/* verif/mem_bus_model.sv */
`timescale 1ns/1ps
module mem_bus_model
    import cpu_logic_branch_decode_pkg::*;
(
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_op1,
    input wire logic [7:0] i_op2,
    output instr_t o_instr
);
    // Every data location follows one fixed pattern, so the bench can predict each operand byte
    always_comb begin
        o_instr.opcode = i_opcode;
        o_instr.op1 = i_op1;
        o_instr.op2 = i_op2;
        o_instr.mem = i_op1 ^ 8'h5A;
        o_instr.stack_pc = {i_op2, i_op1};
        o_instr.stack_ccr = i_op1 ^ i_op2;
    end
endmodule : mem_bus_model

/* verif/cpu_logic_branch_decode_tb.sv */
`timescale 1ns/1ps
module cpu_logic_branch_decode_tb import cpu_logic_branch_decode_pkg::*;;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_start = 1'b0;
    logic [7:0] p_op = 8'h00;
    logic [7:0] p_op1 = 8'h00;
    logic [7:0] p_op2 = 8'h00;
    core_regs_t i_regs = '0;
    instr_t i_instr;
    logic o_ready;
    logic o_done;
    logic o_illegal;
    core_regs_t o_result;
    int num_errors = 0;
    int comparisons = 0;

    mem_bus_model mem_bus_model_inst (.i_opcode(p_op), .i_op1(p_op1), .i_op2(p_op2), .o_instr(i_instr));
    cpu_logic_branch_decode cpu_logic_branch_decode_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_start(i_start), .i_instr(i_instr), .i_regs(i_regs), .o_ready(o_ready), .o_done(o_done),
        .o_illegal(o_illegal), .o_result(o_result));

    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic print_verdict();
        $display("Mismatches %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic check_regs(input core_regs_t got, input core_regs_t exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t result %h expected %h", $time, got, exp);
        end
    endtask : check_regs

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : check_val

    function automatic core_regs_t expect_of(input logic [7:0] op, input logic [7:0] op1,
        input logic [7:0] op2, input core_regs_t r, output logic [7:0] n);
        core_regs_t e;
        logic [7:0] v;
        logic [7:0] res;
        logic f;
        logic [15:0] b;
        e = r;
        n = 8'h03;
        v = op1 ^ 8'h5A;
        if (op == 8'h66 || op == 8'h67 || op[7:3] == 5'b01101 || op == 8'h72 || (op >= 8'h74 && op != 8'h7F + 8'h01 && op[7:4] == 4'h7)) begin
            v = (op == 8'h72) ? r.t[7:0] : (op == 8'h74) ? op1 : v;
            res = op[4] ? (r.a[7:0] | v) : (r.a[7:0] & v);
            e.a[7:0] = res;
            e.ccr[3] = res[7];
            e.ccr[2] = (res == 8'h00);
            e.ccr[1] = 1'b0;
            n = (op == 8'h66 || op == 8'h76) ? 8'h04 : (op == 8'h72 || op == 8'h74) ? 8'h02 : 8'h03;
            e.pc = r.pc + ((op == 8'h66 || op == 8'h74 || op == 8'h75 || op == 8'h76) ? 16'h0002 : 16'h0001);
        end else if (op >= 8'hF8) begin
            f = op[2] ? (op[1] ? (r.ccr[1] ^ r.ccr[3]) : r.ccr[2]) : (op[1] ? r.ccr[3] : r.ccr[0]);
            b = r.pc + 16'h0002;
            e.pc = (f == op[0]) ? b + {{8{op1[7]}}, op1} : b;
        end else if (op[7:4] == 4'hB) begin
            f = v[op[2:0]];
            e.ccr[2] = ~f;
            b = r.pc + 16'h0003;
            e.pc = (f == op[3]) ? b + {{8{op2[7]}}, op2} : b;
            n = 8'h05;
        end else if (op == 8'hC1 || op == 8'hD1) begin
            e.sp = op[4] ? r.sp - 16'h0001 : r.sp + 16'h0001;
            e.pc = r.pc + 16'h0001;
        end else if (op == 8'hF4) begin
            e.a = r.pc + 16'h0001;
            e.pc = r.a;
        end else if (op == 8'h30) begin
            e.pc = {op2, op1};
            e.ccr = op1 ^ op2;
            e.sp = r.sp + 16'h0004;
            n = 8'h06;
        end else begin
            n = 8'h00;
        end
        return e;
    endfunction : expect_of

    // Starts in the done cycle of the previous request, so every call after the first also runs back to back
    task automatic run(input logic [7:0] op, input logic [7:0] op1, input logic [7:0] op2,
        input core_regs_t r, input bit hold);
        core_regs_t e;
        logic [7:0] n;
        logic [7:0] k;
        e = expect_of(op, op1, op2, r, n);
        p_op = op;
        p_op1 = op1;
        p_op2 = op2;
        i_regs = r;
        i_start = 1'b1;
        @(posedge i_mclk);
        #1;
        check_val({7'h00, o_ready}, {7'h00, n == 8'h00});
        if (hold) begin
            p_op = 8'hD1;
        end else begin
            i_start = 1'b0;
        end
        k = 8'h00;
        while (o_done !== 1'b1 && k < 8'h14) begin
            @(posedge i_mclk);
            #1;
            k++;
            if (k == 8'h02) begin
                i_start = 1'b0;
            end
        end
        check_val(k, n);
        check_val({7'h00, o_illegal}, {7'h00, n == 8'h00});
        check_val({7'h00, o_ready}, 8'h01);
        check_regs(o_result, e);
    endtask : run

    task automatic test_logic();
        for (int j = 8'h66; j <= 8'h7F; j++) begin
            if (j != 8'h70 && j != 8'h71 && j != 8'h73 && (j < 8'h69 || j > 8'h6F || j == 8'h6F)) begin
                run(8'(j), 8'h5A, 8'h00, '{16'h1200, 16'h5500, 16'h0100, 16'h2000, 8'h0F}, 1'b0);
                run(8'(j), 8'h3C, 8'h00, '{16'h34C3, 16'h0081, 16'h0100, 16'hFFFF, 8'h02}, 1'b0);
            end
        end
    endtask : test_logic

    task automatic test_branches();
        for (int j = 8'hF8; j <= 8'hFF; j++) begin
            for (int c = 0; c < 16; c++) begin
                run(8'(j), 8'h80, 8'h00, '{16'h1111, 16'h2222, 16'h3333, 16'hFFF0, 8'(c)}, 1'b0);
                run(8'(j), 8'h7F, 8'h00, '{16'h1111, 16'h2222, 16'h3333, 16'h0040, 8'(c)}, 1'b0);
            end
        end
    endtask : test_branches

    task automatic test_bit_branch();
        for (int j = 8'hB0; j <= 8'hBF; j++) begin
            run(8'(j), 8'h5A, 8'hF0, '{16'h0001, 16'h0002, 16'h0003, 16'h8000, 8'h04}, 1'b0);
            run(8'(j), 8'hA5, 8'h10, '{16'h0001, 16'h0002, 16'h0003, 16'h8000, 8'h0B}, 1'b0);
        end
    endtask : test_bit_branch

    task automatic test_misc();
        run(8'hC1, 8'h00, 8'h00, '{16'h0000, 16'h0000, 16'hFFFF, 16'h0100, 8'h0A}, 1'b0);
        run(8'hD1, 8'h00, 8'h00, '{16'h0000, 16'h0000, 16'h0000, 16'h0100, 8'h05}, 1'b0);
        run(8'hF4, 8'h00, 8'h00, '{16'h8000, 16'h0000, 16'h0000, 16'hFFFF, 8'h0F}, 1'b0);
        run(8'h30, 8'h9C, 8'h4D, '{16'h0000, 16'h0000, 16'hFFFE, 16'h0100, 8'h00}, 1'b0);
        run(8'h00, 8'h00, 8'h00, '{16'hABCD, 16'h0000, 16'h0000, 16'h0100, 8'h05}, 1'b0);
        run(8'h73, 8'h00, 8'h00, '{16'hABCD, 16'h0000, 16'h0000, 16'h0100, 8'h05}, 1'b0);
    endtask : test_misc

    task automatic test_refused();
        // A second start while busy must leave the first operation and its timing untouched
        run(8'hC1, 8'h00, 8'h00, '{16'h0000, 16'h0000, 16'h7FFF, 16'h0200, 8'h00}, 1'b1);
    endtask : test_refused

    initial begin
        repeat (8) @(posedge i_mclk);
        #1;
        i_sys_rst = 1'b0;
        @(posedge i_mclk);
        #1;
        check_val({7'h00, o_ready}, 8'h01);
        test_logic();
        test_branches();
        test_bit_branch();
        test_misc();
        test_refused();
        print_verdict();
    end

    initial begin
        #300000;
        num_errors++;
        print_verdict();
    end
endmodule : cpu_logic_branch_decode_tb
